//--- pkg/fmbp_pkg.sv
package fmbp_pkg;
    // register byte offsets (word aligned)
    localparam logic [3:0] OFF_CTRL   = 4'h0;  // mode select and reset bits
    localparam logic [3:0] OFF_CMD    = 4'h4;  // command and address
    localparam logic [3:0] OFF_STATUS = 4'h8;  // ready, errors, sticky events
    localparam logic [3:0] OFF_MASK   = 4'hC;  // interrupt mask
    localparam logic [3:0] OFF_LOCK   = 4'h0;  // unused alias guard
    // control register field positions
    localparam int CTRL_REWRITE_BIT = 1;       // rewrite_mode_select
    localparam int CTRL_LKDIS_BIT   = 2;       // lock bit disable
    localparam int CTRL_FRESET_BIT  = 3;       // flash_controller_reset
    // status register field positions
    localparam int ST_READY_BIT     = 0;       // flash_ready_busy_flag
    localparam int ST_DONE_BIT      = 1;       // sticky: op finished
    localparam int ST_ERR_BIT       = 2;       // sticky: op refused
    localparam int ST_W             = 3;
    // geometry
    localparam int PAGE_BYTES       = 256;
    localparam int NUM_BLOCKS       = 8;       // block 0 is the boot area
    localparam int BOOT_BLOCK       = 0;
    localparam int BOOT_KBYTES      = 8;
    localparam int BLK_W            = 3;
    // operation times in microseconds and their cycle counts at 50 MHz
    localparam int CLK_MHZ          = 50;
    localparam int PROG_US          = 2;
    localparam int ERASE_US         = 20;
    localparam int PROG_CYC         = PROG_US * CLK_MHZ;
    localparam int ERASE_CYC        = ERASE_US * CLK_MHZ;
    localparam int CNT_W            = 16;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;
    // operating modes
    typedef enum logic [2:0] {
        FMBP_MODE_PAR = 3'b001,  // parallel programmer
        FMBP_MODE_SER = 3'b010,  // serial programmer
        FMBP_MODE_CPU = 3'b100   // processor driven rewrite
    } fmbp_mode_t;
    // the eight software commands
    typedef enum logic [2:0] {
        FMBP_CMD_READ_ARRAY  = 3'h0,
        FMBP_CMD_READ_STATUS = 3'h1,
        FMBP_CMD_CLR_STATUS  = 3'h2,
        FMBP_CMD_PROGRAM     = 3'h3,
        FMBP_CMD_BLOCK_ERASE = 3'h4,
        FMBP_CMD_ALL_ERASE   = 3'h5,
        FMBP_CMD_LOCK_PROG   = 3'h6,
        FMBP_CMD_READ_LOCK   = 3'h7
    } fmbp_cmd_t;
    // sequencer states
    typedef enum logic [3:0] {
        FMBP_ST_IDLE  = 4'b0001,
        FMBP_ST_PROG  = 4'b0010,
        FMBP_ST_ERASE = 4'b0100,
        FMBP_ST_LOCK  = 4'b1000
    } fmbp_state_t;
endpackage

//--- design/fmbp_ctrl.sv
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
module fmbp_ctrl (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic [2:0]  i_mode,          // one-hot operating mode
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_ext_req,       // programmer command strobe
    input  wire logic [2:0]  i_ext_cmd,
    input  wire logic [15:0] i_ext_addr,
    input  wire logic        i_cpu_fetch,     // cpu array read request
    output logic             o_fetch_blocked,
    output logic             o_array_we,      // page program byte write strobe
    output logic             o_array_erase,
    output logic             o_array_all,
    output logic [fmbp_pkg::BLK_W-1:0] o_array_blk,
    output logic [15:0]      o_array_addr,
    output logic [7:0]       o_lock_bits,
    output logic             o_busy,
    output logic             o_irq
);
    // block index width, shared with the block port
    localparam int BLK_W = fmbp_pkg::BLK_W;

    // state
    logic [7:0]  ctrl_ff, nxt_ctrl;        // control register
    logic        arm_ff, nxt_arm;          // previous write cleared select
    logic        lkarm_ff, nxt_lkarm;      // same for lock disable
    logic [2:0]  mask_ff, nxt_mask;        // interrupt mask
    logic [2:0]  sticky_ff, nxt_sticky;    // done/error events
    logic [7:0]  lock_ff, nxt_lock;        // 1 = unlocked per block
    fmbp_pkg::fmbp_state_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;          // operation timer
    logic [15:0] addr_ff, nxt_addr;
    logic        all_ff, nxt_all;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        ack_ff, nxt_ack;          // one-cycle wait state
    logic [7:0]  pg_ff, nxt_pg;            // page byte counter

    // decoded helpers
    logic        rw_mode, fres, wr_ctrl, wr_cmd, rd_st, req_cmd;
    logic [2:0]  cmd;
    logic [15:0] cmd_addr;
    logic [BLK_W-1:0] blk;
    logic        allowed, is_write_op;

    // bus decodes act on the first cycle of a request only,
    // so a held request is never taken twice
    assign rw_mode = ctrl_ff[fmbp_pkg::CTRL_REWRITE_BIT];
    assign fres    = ctrl_ff[fmbp_pkg::CTRL_FRESET_BIT] & rw_mode;
    assign wr_ctrl = i_avs_write & ~ack_ff
                   & (i_avs_address == fmbp_pkg::OFF_CTRL);
    assign wr_cmd  = i_avs_write & ~ack_ff
                   & (i_avs_address == fmbp_pkg::OFF_CMD);
    assign rd_st   = i_avs_read & ~ack_ff
                   & (i_avs_address == fmbp_pkg::OFF_STATUS);

    // select command source by mode
    always_comb begin
        req_cmd  = 1'b0;
        cmd      = 3'h0;
        cmd_addr = 16'h0000;
        if (i_mode == fmbp_pkg::FMBP_MODE_CPU) begin
            // only full 16-bit writes to even addresses count
            req_cmd  = wr_cmd & rw_mode & ~i_avs_writedata[0]
                     & (i_avs_byteenable[1:0] == 2'b11);
            cmd      = i_avs_writedata[18:16];
            cmd_addr = i_avs_writedata[15:0];
        end else if (i_mode == fmbp_pkg::FMBP_MODE_PAR ||
                     i_mode == fmbp_pkg::FMBP_MODE_SER) begin
            req_cmd  = i_ext_req;
            cmd      = i_ext_cmd;
            cmd_addr = i_ext_addr;
        end else begin
            req_cmd  = 1'b0;
        end
    end

    // block index is the top address bits; block 0 is 8 KB boot
    assign blk = cmd_addr[15:13];
    assign is_write_op = (cmd == fmbp_pkg::FMBP_CMD_PROGRAM)
                       | (cmd == fmbp_pkg::FMBP_CMD_BLOCK_ERASE)
                       | (cmd == fmbp_pkg::FMBP_CMD_LOCK_PROG);

    // protection check for the addressed block
    always_comb begin
        allowed = 1'b1;
        if (blk == BLK_W'(fmbp_pkg::BOOT_BLOCK) &&
            i_mode != fmbp_pkg::FMBP_MODE_PAR)
            allowed = 1'b0;
        else if (!lock_ff[blk] && !ctrl_ff[fmbp_pkg::CTRL_LKDIS_BIT])
            allowed = 1'b0;
    end

    // control register, bus answer and status
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_arm    = arm_ff;
        nxt_lkarm  = lkarm_ff;
        nxt_mask   = mask_ff;
        nxt_rdata  = rdata_ff;
        nxt_ack    = (i_avs_read | i_avs_write) & ~ack_ff;
        if (wr_ctrl && i_avs_byteenable[0]) begin
            // select sets only after a write of 0
            if (!i_avs_writedata[fmbp_pkg::CTRL_REWRITE_BIT]) begin
                nxt_ctrl[fmbp_pkg::CTRL_REWRITE_BIT] = 1'b0;
                nxt_arm = 1'b1;
            end else begin
                nxt_ctrl[fmbp_pkg::CTRL_REWRITE_BIT] = arm_ff | rw_mode;
                nxt_arm = 1'b0;
            end
            // lock disable follows the same rule, rewrite mode only
            if (rw_mode) begin
                if (!i_avs_writedata[fmbp_pkg::CTRL_LKDIS_BIT]) begin
                    nxt_ctrl[fmbp_pkg::CTRL_LKDIS_BIT] = 1'b0;
                    nxt_lkarm = 1'b1;
                end else begin
                    nxt_ctrl[fmbp_pkg::CTRL_LKDIS_BIT] =
                        lkarm_ff | ctrl_ff[fmbp_pkg::CTRL_LKDIS_BIT];
                    nxt_lkarm = 1'b0;
                end
                nxt_ctrl[fmbp_pkg::CTRL_FRESET_BIT] =
                    i_avs_writedata[fmbp_pkg::CTRL_FRESET_BIT];
            end else begin
                nxt_ctrl[fmbp_pkg::CTRL_LKDIS_BIT]  = 1'b0;
                nxt_ctrl[fmbp_pkg::CTRL_FRESET_BIT] = 1'b0;
            end
        end else if (i_avs_write && !ack_ff) begin
            nxt_arm   = 1'b0; // any other write breaks the sequence
            nxt_lkarm = 1'b0;
        end
        if (i_avs_write && !ack_ff && i_avs_byteenable[0] &&
            i_avs_address == fmbp_pkg::OFF_MASK)
            nxt_mask = i_avs_writedata[2:0];
        // read data, unmapped reads as zero
        if (i_avs_read && !ack_ff) begin
            case (i_avs_address)
                fmbp_pkg::OFF_CTRL:
                    nxt_rdata = {24'h00_0000, ctrl_ff};
                fmbp_pkg::OFF_STATUS:
                    nxt_rdata = {21'h0_0000, lock_ff,
                        sticky_ff[2:1], st_ff == fmbp_pkg::FMBP_ST_IDLE};
                fmbp_pkg::OFF_MASK:
                    nxt_rdata = {29'h000_0000, mask_ff};
                default:
                    nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    // sequencer: page program, block/all erase, lock program
    always_comb begin
        nxt_st     = st_ff;
        nxt_cnt    = cnt_ff;
        nxt_addr   = addr_ff;
        nxt_all    = all_ff;
        nxt_lock   = lock_ff;
        nxt_pg     = pg_ff;
        nxt_sticky = sticky_ff;
        if (rd_st)
            nxt_sticky = 3'h0; // read clears, set below wins
        o_array_we    = 1'b0;
        o_array_erase = 1'b0;
        o_array_all   = 1'b0;
        case (st_ff)
            fmbp_pkg::FMBP_ST_IDLE: begin
                if (req_cmd && is_write_op && !allowed) begin
                    nxt_sticky[fmbp_pkg::ST_ERR_BIT] = 1'b1;
                end else if (req_cmd) begin
                    nxt_addr = cmd_addr;
                    case (cmd)
                        fmbp_pkg::FMBP_CMD_PROGRAM: begin
                            nxt_st  = fmbp_pkg::FMBP_ST_PROG;
                            nxt_cnt = 16'(fmbp_pkg::PROG_CYC);
                            nxt_pg  = 8'h00;
                        end
                        fmbp_pkg::FMBP_CMD_BLOCK_ERASE,
                        fmbp_pkg::FMBP_CMD_ALL_ERASE: begin
                            nxt_st  = fmbp_pkg::FMBP_ST_ERASE;
                            nxt_cnt = 16'(fmbp_pkg::ERASE_CYC);
                            nxt_all = (cmd == fmbp_pkg::FMBP_CMD_ALL_ERASE);
                        end
                        fmbp_pkg::FMBP_CMD_LOCK_PROG: begin
                            nxt_st  = fmbp_pkg::FMBP_ST_LOCK;
                            nxt_cnt = 16'(fmbp_pkg::PROG_CYC);
                        end
                        fmbp_pkg::FMBP_CMD_CLR_STATUS:
                            nxt_sticky = 3'h0;
                        default: nxt_st = fmbp_pkg::FMBP_ST_IDLE;
                    endcase
                end
            end
            fmbp_pkg::FMBP_ST_PROG: begin
                // one byte per cycle across the whole page
                o_array_we = 1'b1;
                nxt_pg = pg_ff + 8'h01;
                if (pg_ff == 8'(fmbp_pkg::PAGE_BYTES - 1)) begin
                    nxt_st = fmbp_pkg::FMBP_ST_IDLE;
                    nxt_sticky[fmbp_pkg::ST_DONE_BIT] = 1'b1;
                end
            end
            fmbp_pkg::FMBP_ST_ERASE: begin
                nxt_cnt = cnt_ff - 16'h0001;
                if (cnt_ff == 16'h0001) begin
                    o_array_erase = 1'b1;
                    o_array_all   = all_ff;
                    // erase with lock disabled unlocks erased blocks
                    if (ctrl_ff[fmbp_pkg::CTRL_LKDIS_BIT]) begin
                        if (all_ff)
                            nxt_lock = 8'hFF;
                        else
                            nxt_lock[addr_ff[15:13]] = 1'b1;
                    end
                    nxt_st = fmbp_pkg::FMBP_ST_IDLE;
                    nxt_sticky[fmbp_pkg::ST_DONE_BIT] = 1'b1;
                end
            end
            fmbp_pkg::FMBP_ST_LOCK: begin
                nxt_cnt = cnt_ff - 16'h0001;
                if (cnt_ff == 16'h0001) begin
                    nxt_lock[addr_ff[15:13]] = 1'b0;
                    nxt_st = fmbp_pkg::FMBP_ST_IDLE;
                    nxt_sticky[fmbp_pkg::ST_DONE_BIT] = 1'b1;
                end
            end
            default: nxt_st = fmbp_pkg::FMBP_ST_IDLE;
        endcase
    end

    // registers; flash reset clears the sequencer only
    // lock bits survive a flash reset: only a system reset,
    // or an erase with lock disable set, may unlock a block
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ctrl_ff  <= fmbp_pkg::CTRL_RST;
            arm_ff   <= 1'b0;
            lkarm_ff <= 1'b0;
            mask_ff  <= fmbp_pkg::MASK_RST;
            rdata_ff <= 32'h0000_0000;
            ack_ff   <= 1'b0;
            lock_ff  <= 8'hFF;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            arm_ff   <= nxt_arm;
            lkarm_ff <= nxt_lkarm;
            mask_ff  <= nxt_mask;
            rdata_ff <= nxt_rdata;
            ack_ff   <= nxt_ack;
            lock_ff  <= fres ? lock_ff : nxt_lock;
        end
    end

    // sequencer registers; a flash reset aborts any running
    // operation and drops pending events
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst || fres) begin
            st_ff     <= fmbp_pkg::FMBP_ST_IDLE;
            cnt_ff    <= 16'h0000;
            addr_ff   <= 16'h0000;
            all_ff    <= 1'b0;
            pg_ff     <= 8'h00;
            sticky_ff <= 3'h0;
        end else begin
            st_ff     <= nxt_st;
            cnt_ff    <= nxt_cnt;
            addr_ff   <= nxt_addr;
            all_ff    <= nxt_all;
            pg_ff     <= nxt_pg;
            sticky_ff <= nxt_sticky;
        end
    end

    // outputs
    // waitrequest drops in the second cycle of every request
    assign o_avs_readdata    = rdata_ff;
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_ff;
    assign o_fetch_blocked   = i_cpu_fetch & rw_mode;
    assign o_array_blk       = addr_ff[15:13];
    assign o_array_addr      = {addr_ff[15:8], pg_ff};
    assign o_lock_bits       = lock_ff;
    assign o_busy            = (st_ff != fmbp_pkg::FMBP_ST_IDLE);
    assign o_irq             = |(sticky_ff & mask_ff);
endmodule

//--- tb/fmbp_ctrl_assertions.sv
`timescale 1ns/10ps
module fmbp_ctrl_checker (
    input wire logic                     i_ref_clk,
    input wire logic                     i_sys_rst,
    input wire logic [2:0]               i_mode,
    input wire logic                     i_avs_read,
    input wire logic                     i_avs_write,
    input wire logic                     o_avs_waitrequest,
    input wire logic                     i_cpu_fetch,
    input wire logic                     o_fetch_blocked,
    input wire logic                     o_array_we,
    input wire logic                     o_array_erase,
    input wire logic                     o_array_all,
    input wire logic [fmbp_pkg::BLK_W-1:0] o_array_blk,
    input wire logic [15:0]              o_array_addr,
    input wire logic [7:0]               o_lock_bits,
    input wire logic                     o_busy
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    // length of the current page write burst
    logic [15:0] we_cnt_ff;
    logic [15:0] nxt_we_cnt;
    always_comb nxt_we_cnt = o_array_we ? we_cnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge i_ref_clk) begin
        we_cnt_ff <= i_sys_rst ? 16'h0000 : nxt_we_cnt;
    end
    // length of the current busy stretch; the longest is one erase
    logic [15:0] busy_cnt_ff;
    logic [15:0] nxt_busy_cnt;
    always_comb nxt_busy_cnt = o_busy ? busy_cnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge i_ref_clk) begin
        busy_cnt_ff <= i_sys_rst ? 16'h0000 : nxt_busy_cnt;
    end
    fetch_gate_a: assert property (
        o_fetch_blocked |-> i_cpu_fetch) else $error("fetch blocked idle");
    bus_answer_a: assert property (
        (i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
        else $error("bus answer late");
    page_len_a: assert property (
        $fell(o_array_we) |-> we_cnt_ff == 16'h0100)
        else $error("page burst length wrong");
    erase_pulse_a: assert property (
        o_array_erase |=> !o_array_erase) else $error("erase pulse long");
    busy_bound_a: assert property (
        busy_cnt_ff <= 16'(fmbp_pkg::ERASE_CYC)) else $error("busy stuck");
    we_busy_a: assert property (
        o_array_we |-> o_busy) else $error("write while ready");
    boot_prog_a: assert property (
        o_array_we && o_array_addr[15:13] == 3'h0
        |-> i_mode == fmbp_pkg::FMBP_MODE_PAR) else $error("boot written");
    boot_erase_a: assert property (
        o_array_erase && !o_array_all && o_array_blk == 3'h0
        |-> i_mode == fmbp_pkg::FMBP_MODE_PAR) else $error("boot erased");
    lock_change_a: assert property (
        !$stable(o_lock_bits) |-> $past(o_busy) || $past(o_busy, 2))
        else $error("lock bits moved while idle");
endmodule
bind fmbp_ctrl fmbp_ctrl_checker chk_u (.i_ref_clk, .i_sys_rst, .i_mode,
    .i_avs_read, .i_avs_write, .o_avs_waitrequest, .i_cpu_fetch,
    .o_fetch_blocked, .o_array_we, .o_array_erase, .o_array_all,
    .o_array_blk, .o_array_addr, .o_lock_bits, .o_busy);

//--- tb/fmbp_prog_model.sv
`timescale 1ns/10ps
module fmbp_prog_model (
    input  wire logic  i_ref_clk,
    output logic       o_ext_req,
    output logic [2:0] o_ext_cmd,
    output logic [15:0] o_ext_addr
);
    initial begin
        o_ext_req = 1'b0;
        o_ext_cmd = 3'h0;
        o_ext_addr = 16'h0000;
    end
    // one-cycle programmer strobe, lines inverted once released
    task send(input logic [2:0] c, input logic [15:0] a);
        @(posedge i_ref_clk);
        o_ext_req <= 1'b1;
        o_ext_cmd <= c;
        o_ext_addr <= a;
        @(posedge i_ref_clk);
        o_ext_req <= 1'b0;
        o_ext_cmd <= ~c;
        o_ext_addr <= ~a;
    endtask
endmodule

//--- tb/fmbp_ctrl_bench.sv
`timescale 1ns/10ps
module fmbp_ctrl_bench;
    logic        clk, rst, rd_r, wr_r, fetch, wq, fblk, busy, irq, ereq;
    logic [2:0]  mode, ecmd;
    logic [3:0]  adr, ben;
    logic [15:0] eaddr, page;
    logic [31:0] wdat, rdata, exp_q[$], msk_q[$];
    logic [7:0]  locks;
    int          fails, comparisons;
    fmbp_ctrl dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_mode(mode),
        .i_avs_address(adr), .i_avs_read(rd_r), .i_avs_write(wr_r),
        .i_avs_writedata(wdat), .i_avs_byteenable(ben),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wq), .i_ext_req(ereq),
        .i_ext_cmd(ecmd), .i_ext_addr(eaddr), .i_cpu_fetch(fetch),
        .o_fetch_blocked(fblk), .o_array_we(), .o_array_erase(),
        .o_array_all(), .o_array_blk(), .o_array_addr(),
        .o_lock_bits(locks), .o_busy(busy), .o_irq(irq));
    fmbp_prog_model prog_u (.i_ref_clk(clk), .o_ext_req(ereq),
        .o_ext_cmd(ecmd), .o_ext_addr(eaddr));
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // avalon cycle held until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wdat <= d;
        rd_r <= !w;
        wr_r <= w;
        @(posedge clk);
        while (wq !== 1'b0) @(posedge clk);
        rd_r <= 1'b0;
        wr_r <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task cmd(input logic [2:0] c, input logic [15:0] a);
        bus(1'b1, fmbp_pkg::OFF_CMD, {13'h0, c, a});
    endtask
    // check start of operation, optionally ready low, then wait out
    task run(input logic eb, input logic st);
        repeat (2) @(posedge clk);
        chk("busy", {31'h0, eb}, {31'h0, busy});
        if (st) rd(fmbp_pkg::OFF_STATUS, 32'h0000_0000, 32'h0000_0001);
        while (busy !== 1'b0) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task irq_is(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // read results compared as they appear
    always @(posedge clk) begin
        if (rd_r && wq === 1'b0 && exp_q.size() > 0)
            chk("readdata", exp_q.pop_front(), rdata & msk_q.pop_front());
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        finish_test;
    end
    initial begin
        {rst, rd_r, wr_r, fetch, adr, ben, wdat} = {3'b100, 5'h0, 4'hF, 32'h0};
        mode = fmbp_pkg::FMBP_MODE_CPU;
        void'($urandom(82));
        page = {3'(1 + $urandom % 3), 5'($urandom), 8'h00};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_07F9, 32'h0000_07FF);
        rd(fmbp_pkg::OFF_CTRL, 32'h0000_0000, 32'h0000_000E);
        bus(1'b1, fmbp_pkg::OFF_STATUS, 32'h0000_0000);
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0001);
        bus(1'b1, fmbp_pkg::OFF_MASK, 32'h0000_0002);
        bus(1'b1, fmbp_pkg::OFF_CTRL, 32'h0000_0000);
        bus(1'b1, fmbp_pkg::OFF_CTRL, 32'h0000_0002);
        fetch <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        chk("fetch blocked", 32'h1, {31'h0, fblk});
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h2001);
        run(1'b0, 1'b0);
        ben <= 4'h1;
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h2000);
        ben <= 4'hF;
        run(1'b0, 1'b0);
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, page);
        run(1'b1, 1'b1);
        irq_is(1'b1);
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_0003, 32'h0000_0007);
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_0001, 32'h0000_0007);
        irq_is(1'b0);
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h1F00);
        run(1'b0, 1'b0);
        irq_is(1'b0);
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_0005, 32'h0000_0007);
        cmd(fmbp_pkg::FMBP_CMD_LOCK_PROG, 16'h4000);
        run(1'b1, 1'b0);
        chk("locks", 32'h0000_00FB, {24'h0, locks});
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h4000);
        run(1'b0, 1'b0);
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_0007, 32'h0000_0007);
        cmd(fmbp_pkg::FMBP_CMD_BLOCK_ERASE, 16'h6000);
        run(1'b1, 1'b1);
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_0003, 32'h0000_0007);
        bus(1'b1, fmbp_pkg::OFF_MASK, 32'h0000_0006);
        cmd(fmbp_pkg::FMBP_CMD_BLOCK_ERASE, 16'h0000);
        run(1'b0, 1'b0);
        irq_is(1'b1);
        rd(fmbp_pkg::OFF_STATUS, 32'h0000_0005, 32'h0000_0007);
        irq_is(1'b0);
        cmd(fmbp_pkg::FMBP_CMD_ALL_ERASE, 16'h0000);
        run(1'b1, 1'b1);
        irq_is(1'b1);
        for (int i = 0; i < 8; i++) begin
            if (i < 3 || i == 7) cmd(3'(i), 16'h2000);
            repeat (4) @(posedge clk);
        end
        irq_is(1'b0);
        bus(1'b1, fmbp_pkg::OFF_CTRL, 32'h0000_000A);
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h2000);
        run(1'b0, 1'b0);
        bus(1'b1, fmbp_pkg::OFF_CTRL, 32'h0000_0002);
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h2100);
        run(1'b1, 1'b1);
        bus(1'b1, fmbp_pkg::OFF_CTRL, 32'h0000_0000);
        @(posedge clk);
        @(posedge clk);
        chk("fetch blocked", 32'h0, {31'h0, fblk});
        cmd(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h2200);
        run(1'b0, 1'b0);
        mode <= fmbp_pkg::FMBP_MODE_PAR;
        prog_u.send(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h0100);
        run(1'b1, 1'b0);
        prog_u.send(fmbp_pkg::FMBP_CMD_BLOCK_ERASE, 16'h0000);
        run(1'b1, 1'b0);
        mode <= fmbp_pkg::FMBP_MODE_SER;
        prog_u.send(fmbp_pkg::FMBP_CMD_PROGRAM, 16'h0200);
        run(1'b0, 1'b0);
        finish_test;
    end
endmodule
